/* psmp_cfg.svh */
// Constants of the programmable synchronous memory port.
// Assumes byte addressing on an APB bus with 32-bit data.
`ifndef PSMP_CFG_SVH
`define PSMP_CFG_SVH

`define PSMP_SPACES          4
`define PSMP_OFF_SEC0        12'h000
`define PSMP_OFF_SEC1        12'h004
`define PSMP_OFF_SEC2        12'h008
`define PSMP_OFF_SEC3        12'h00C
`define PSMP_OFF_ADDR        12'h010
`define PSMP_OFF_WDATA       12'h014
`define PSMP_OFF_CMD         12'h018
`define PSMP_OFF_STATUS      12'h01C
`define PSMP_OFF_RDATA       12'h020

`define PSMP_SEC_RL_LSB      0
`define PSMP_SEC_WL_LSB      2
`define PSMP_SEC_CHIP_ENABLE_EXTEND_BIT   4
`define PSMP_SEC_READ_ENABLE_STROBE_SEL_BIT   5
`define PSMP_SEC_CLKSEL_BIT  6
`define PSMP_SEC_W           7
`define PSMP_SEC_RESET       7'h00

`define PSMP_CMD_READ_BIT    0
`define PSMP_CMD_SPACE_LSB   1
`define PSMP_STAT_BUSY_BIT   0
`define PSMP_STAT_ERR_BIT    1

`define PSMP_DESELECT_TICKS  2'h1

`endif

/* psmp_pkg.sv */
// Types of the programmable synchronous memory port.
// Assumes psmp_cfg.svh is on the include path.
`include "psmp_cfg.svh"

package psmp_pkg;

  typedef struct packed {
    logic       clk_sel;
    logic       read_enable_strobe_sel;
    logic       chip_enable_extend;
    logic [1:0] write_latency_sel;
    logic [1:0] read_latency_sel;
  } psmp_sec_t;

  typedef struct packed {
    logic chip_enable_n;
    logic strobe_n;
    logic output_enable_n;
    logic write_enable_n;
  } psmp_ctl_t;

  typedef enum logic [2:0] {
    PSMP_IDLE,
    PSMP_ARM,
    PSMP_RD_WAIT,
    PSMP_WR_WAIT,
    PSMP_DESEL
  } psmp_state_t;

endpackage

/* psmp_port.sv */
// Programmable synchronous memory port: APB registers and the sync
// SRAM / ZBT / FIFO pin sequencer for one memory port instance.
// Assumes both external output clocks and read data come from outside
// the pclk domain; they are resynchronised here.
//
// Function
// - Read latency 0..3 per space
// - Write latency 0..3 per space
// - Extend off: chip enable drops after command
// - Extend on: chip enable follows output enable on reads
// - Strobe select 0: address strobe, deselect cycles
// - Strobe select 1: FIFO read enable, no deselect
// - Each space picks one of two clocks
// - Three control pins take sync roles
// - Per-space secondary control register holds settings
// - Two port instances, told apart by PORT_NARROW
`timescale 1ns/1ps
`default_nettype none
`include "psmp_cfg.svh"

module psmp_port #(
  parameter int ADDR_W      = 20,
  parameter int DATA_W      = 32,
  parameter bit PORT_NARROW = 1'b0
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output var  logic [31:0]             prdata,
  output var  logic                    pready,
  output var  logic                    pslverr,
  input  wire logic                    ext_clock_out_one,
  input  wire logic                    ext_clock_out_two,
  output var  logic [`PSMP_SPACES-1:0] space_chip_enable_n,
  output var  logic                    addr_strobe_or_read_enable_n,
  output var  logic                    sync_output_enable_n,
  output var  logic                    sync_write_enable_n,
  output var  logic [ADDR_W-1:0]       mem_addr,
  output var  logic [DATA_W-1:0]       mem_data_out,
  output var  logic                    mem_data_oe,
  input  wire logic [DATA_W-1:0]       mem_data_in,
  output var  logic                    port_is_narrow
);
  import psmp_pkg::*;

  // Register words are 32 bits, so wider fields could not be reached
  if (DATA_W < 1 || DATA_W > 32 || ADDR_W < 1 || ADDR_W > 32) begin : g_bad_width
    $error("psmp_port: unsupported ADDR_W or DATA_W");
  end

  ////////////////////////////////////////////////////////////////////
  // Resynchronisers

  logic [2:0]        clk1_sync;
  logic [2:0]        clk2_sync;
  // Read data stands for the whole latency, so per-bit sync is safe
  logic [DATA_W-1:0] din_meta;
  logic [DATA_W-1:0] din_sync;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk1_sync <= 3'h0;
      clk2_sync <= 3'h0;
      din_meta  <= '0;
      din_sync  <= '0;
    end else begin
      clk1_sync <= {clk1_sync[1:0], ext_clock_out_one};
      clk2_sync <= {clk2_sync[1:0], ext_clock_out_two};
      din_meta  <= mem_data_in;
      din_sync  <= din_meta;
    end
  end

  // One pclk of rise per external edge, so each tick counts once
  function automatic logic rising(input logic [2:0] stages);
    rising = stages[1] & ~stages[2];
  endfunction

  // Stage 0 is only read by stage 1
  wire rise_one = rising(clk1_sync);
  wire rise_two = rising(clk2_sync);

  ////////////////////////////////////////////////////////////////////
  // APB register file

  psmp_sec_t         sec [`PSMP_SPACES];
  logic [ADDR_W-1:0] acc_addr;
  logic [DATA_W-1:0] acc_wdata;
  logic [DATA_W-1:0] acc_rdata;
  logic              busy;
  logic              cmd_err;
  logic              start;
  logic              start_read;
  logic [1:0]        start_space;

  function automatic logic [31:0] sec_word(input psmp_sec_t s);
    sec_word = {25'h0, s};
  endfunction

  wire apb_access = psel & penable;
  wire apb_wr     = apb_access & pwrite;
  wire hit_sec    = (paddr[11:4] == 8'h00) && (paddr[1:0] == 2'h0);
  wire hit_addr   = (paddr == `PSMP_OFF_ADDR);
  wire hit_wdata  = (paddr == `PSMP_OFF_WDATA);
  wire hit_cmd    = (paddr == `PSMP_OFF_CMD);
  wire hit_status = (paddr == `PSMP_OFF_STATUS);
  wire hit_rdata  = (paddr == `PSMP_OFF_RDATA);
  wire hit_any    = hit_sec | hit_addr | hit_wdata | hit_cmd | hit_status | hit_rdata;
  wire [1:0] sec_idx = paddr[3:2];
  // Commands while busy are refused rather than queued
  wire cmd_refused = hit_cmd & busy;

  assign pready  = 1'b1;
  assign pslverr = apb_access & (~hit_any | (pwrite & cmd_refused));
  assign port_is_narrow = PORT_NARROW;

  // Error flag sticks until software writes it back
  wire [31:0] status_word = (32'(cmd_err) << `PSMP_STAT_ERR_BIT)
                          | (32'(busy) << `PSMP_STAT_BUSY_BIT);
  wire [31:0] rd_mux =
    hit_sec    ? sec_word(sec[sec_idx]) :
    hit_addr   ? 32'(acc_addr) :
    hit_wdata  ? 32'(acc_wdata) :
    hit_status ? status_word :
    hit_rdata  ? 32'(acc_rdata) : 32'h0;

  ////////////////////////////////////////////////////////////////////
  // Read data staging

  // Staged in the setup phase so the pin leaves a flop, still 0 wait
  wire apb_setup_rd = psel & ~penable & ~pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else begin
      prdata <= apb_setup_rd ? rd_mux : 32'h0;
    end
  end

  wire cmd_go = apb_wr & hit_cmd & ~busy;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `PSMP_SPACES; i++) begin
        sec[i] <= psmp_sec_t'(`PSMP_SEC_RESET);
      end
      acc_addr    <= '0;
      acc_wdata   <= '0;
      cmd_err     <= 1'b0;
      start       <= 1'b0;
      start_read  <= 1'b0;
      start_space <= 2'h0;
    end else begin
      start <= cmd_go;
      if (apb_wr && hit_sec) begin
        sec[sec_idx] <= psmp_sec_t'(pwdata[`PSMP_SEC_W-1:0]);
      end
      if (apb_wr && hit_addr) begin
        acc_addr <= pwdata[ADDR_W-1:0];
      end
      if (apb_wr && hit_wdata) begin
        acc_wdata <= pwdata[DATA_W-1:0];
      end
      if (cmd_go) begin
        start_read  <= pwdata[`PSMP_CMD_READ_BIT];
        start_space <= pwdata[`PSMP_CMD_SPACE_LSB +: 2];
      end
      if (apb_wr && cmd_refused) begin
        cmd_err <= 1'b1;
      end else if (apb_wr && hit_status && pwdata[`PSMP_STAT_ERR_BIT]) begin
        cmd_err <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pin sequencer

  psmp_state_t state;
  psmp_state_t next_state;
  psmp_sec_t   cur;
  logic [1:0]  cur_space;
  logic        cur_read;
  logic [1:0]  lat_cnt;
  logic [1:0]  next_lat_cnt;
  psmp_ctl_t   ctl;
  psmp_ctl_t   next_ctl;
  logic        next_data_oe;
  logic        capture;

  // Ticks of the clock chosen for the active space
  wire tick = cur.clk_sel ? rise_two : rise_one;

  // One space at most is enabled, the rest held off
  function automatic logic [`PSMP_SPACES-1:0] space_select(input logic       enable_n,
                                                           input logic [1:0] space);
    space_select        = '1;
    space_select[space] = enable_n;
  endfunction

  always_comb begin
    next_state   = state;
    next_lat_cnt = lat_cnt;
    next_ctl     = ctl;
    next_data_oe = mem_data_oe;
    capture      = 1'b0;
    case (state)
      PSMP_IDLE: begin
        next_ctl     = '{1'b1, 1'b1, 1'b1, 1'b1};
        next_data_oe = 1'b0;
        if (start) begin
          next_state = PSMP_ARM;
        end
      end
      PSMP_ARM: begin
        if (tick) begin
          // Command presented at this edge
          next_lat_cnt             = cur_read ? cur.read_latency_sel : cur.write_latency_sel;
          next_ctl.chip_enable_n   = 1'b0;
          // A FIFO read enable must stay off for writes
          next_ctl.strobe_n        = cur.read_enable_strobe_sel & ~cur_read;
          next_ctl.output_enable_n = ~cur_read;
          next_ctl.write_enable_n  = cur_read;
          if (cur_read) begin
            next_state = PSMP_RD_WAIT;
          end else begin
            next_state = PSMP_WR_WAIT;
            if (cur.write_latency_sel == 2'h0) begin
              next_data_oe = 1'b1;
            end
          end
        end
      end
      PSMP_RD_WAIT: begin
        if (tick) begin
          if (!cur.chip_enable_extend) begin
            next_ctl.chip_enable_n = 1'b1;
          end
          if (!cur.read_enable_strobe_sel) begin
            next_ctl.strobe_n = 1'b1;
          end
          if (lat_cnt == 2'h0) begin
            // Data sampled one edge after the latency has run out
            capture                  = 1'b1;
            next_ctl.output_enable_n = 1'b1;
            next_ctl.chip_enable_n   = 1'b1;
            next_ctl.strobe_n        = 1'b1;
            next_lat_cnt             = `PSMP_DESELECT_TICKS;
            next_state = cur.read_enable_strobe_sel ? PSMP_IDLE : PSMP_DESEL;
          end else begin
            next_lat_cnt = lat_cnt - 2'h1;
          end
        end
      end
      PSMP_WR_WAIT: begin
        if (tick) begin
          next_ctl.chip_enable_n  = 1'b1;
          next_ctl.strobe_n       = 1'b1;
          next_ctl.write_enable_n = 1'b1;
          if (mem_data_oe) begin
            next_data_oe = 1'b0;
            next_lat_cnt = `PSMP_DESELECT_TICKS;
            next_state   = cur.read_enable_strobe_sel ? PSMP_IDLE : PSMP_DESEL;
          end else if (lat_cnt == 2'h1) begin
            next_data_oe = 1'b1;
          end else begin
            next_lat_cnt = lat_cnt - 2'h1;
          end
        end
      end
      PSMP_DESEL: begin
        // Idle clocks for SRAMs that need a deselect
        if (tick) begin
          if (lat_cnt <= 2'h1) begin
            next_state = PSMP_IDLE;
          end else begin
            next_lat_cnt = lat_cnt - 2'h1;
          end
        end
      end
      default: begin
        next_state = PSMP_IDLE;
      end
    endcase
  end

  assign busy = (state != PSMP_IDLE) | start;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state       <= PSMP_IDLE;
      lat_cnt     <= 2'h0;
      ctl         <= '{1'b1, 1'b1, 1'b1, 1'b1};
      mem_data_oe <= 1'b0;
      space_chip_enable_n <= '1;
      cur         <= psmp_sec_t'(`PSMP_SEC_RESET);
      cur_space   <= 2'h0;
      cur_read    <= 1'b0;
      acc_rdata   <= '0;
    end else begin
      state       <= next_state;
      lat_cnt     <= next_lat_cnt;
      ctl         <= next_ctl;
      mem_data_oe <= next_data_oe;
      space_chip_enable_n <= space_select(next_ctl.chip_enable_n, cur_space);
      // Settings latched here, so a mid-access SEC write is harmless
      if (start) begin
        cur       <= sec[start_space];
        cur_space <= start_space;
        cur_read  <= start_read;
      end
      if (capture) begin
        acc_rdata <= din_sync;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pin outputs
  // Address and data load at start and hold for the whole access

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_addr     <= '0;
      mem_data_out <= '0;
    end else if (start) begin
      mem_addr     <= acc_addr;
      mem_data_out <= acc_wdata;
    end
  end

  assign addr_strobe_or_read_enable_n = ctl.strobe_n;
  assign sync_output_enable_n         = ctl.output_enable_n;
  assign sync_write_enable_n          = ctl.write_enable_n;

endmodule

`default_nettype wire

/* psmp_port_assertions.sv */
// Checker for psmp_port: APB answers and pin sequencing.
// Assumes binding to psmp_port; clocks one and two are unrelated to pclk.
`timescale 1ns/1ps
`default_nettype none
`include "psmp_cfg.svh"
module psmp_port_assertions #(
  parameter bit PORT_NARROW = 1'b0
) (
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire logic                    ext_clock_out_one,
  input wire logic                    ext_clock_out_two,
  input wire logic [`PSMP_SPACES-1:0] space_chip_enable_n,
  input wire logic                    addr_strobe_or_read_enable_n,
  input wire logic                    sync_output_enable_n,
  input wire logic                    sync_write_enable_n,
  input wire logic                    mem_data_oe,
  input wire logic                    port_is_narrow
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////
  // Age since each raw clock edge, saturating so idle time is quiet
  logic       e1_q, e2_q;
  logic [3:0] age1, age2;
  logic [5:0] pins;
  wire        rise1 = ext_clock_out_one & ~e1_q;
  wire        rise2 = ext_clock_out_two & ~e2_q;
  assign pins = {space_chip_enable_n, sync_output_enable_n, sync_write_enable_n};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {e1_q, e2_q} <= 2'h0;
      {age1, age2} <= 8'hFF;
    end else begin
      {e1_q, e2_q} <= {ext_clock_out_one, ext_clock_out_two};
      age1 <= rise1 ? 4'h0 : age1 + {3'h0, age1 != 4'hF};
      age2 <= rise2 ? 4'h0 : age2 + {3'h0, age2 != 4'hF};
    end
  end
  ////////////////////////////////////////////////////////////////
  zero_wait_a: assert property (psel && penable |-> pready)
    else $error("wait state seen");
  rdata_idle_a: assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0)
    else $error("read data outside read");
  err_access_a: assert property (pslverr |-> psel && penable)
    else $error("error outside access");
  one_space_a: assert property ($onehot0(~space_chip_enable_n))
    else $error("two spaces enabled");
  oe_we_excl_a: assert property (!(!sync_output_enable_n && !sync_write_enable_n))
    else $error("read and write enables together");
  drive_not_read_a: assert property (mem_data_oe |-> sync_output_enable_n)
    else $error("data driven during read");
  read_start_a: assert property ($fell(sync_output_enable_n) |->
    space_chip_enable_n != 4'hF && !addr_strobe_or_read_enable_n)
    else $error("read started without select");
  read_end_a: assert property ($rose(sync_output_enable_n) |-> space_chip_enable_n == 4'hF)
    else $error("chip enable outlived output enable");
  tick_aligned_a: assert property ($changed(pins) |-> age1 <= 4'h8 || age2 <= 4'h8)
    else $error("pin moved off a clock tick");
  port_id_a: assert property (port_is_narrow == PORT_NARROW)
    else $error("port identity wrong");
endmodule
bind psmp_port psmp_port_assertions #(.PORT_NARROW(PORT_NARROW)) i_psmp_port_assertions (
  .pclk, .presetn, .psel, .penable, .pwrite, .prdata, .pready, .pslverr, .ext_clock_out_one,
  .ext_clock_out_two, .space_chip_enable_n, .addr_strobe_or_read_enable_n,
  .sync_output_enable_n, .sync_write_enable_n, .mem_data_oe, .port_is_narrow);
`default_nettype wire

/* psmp_mem_model.sv */
// Behavioural sync memory of one word on the far side of psmp_port.
// Assumes clk is the clock that the accessed space follows.
`timescale 1ns/1ps
`default_nettype none
module psmp_mem_model (
  input  wire logic        clk,
  input  wire logic        oe_n,
  input  wire logic        data_oe,
  input  wire logic [31:0] data_out,
  output var  logic [31:0] data_in
);
  logic [31:0] word = 32'h0;
  logic [31:0] last = 32'h0;
  // Bus released: show inverse of last value, never a kind constant
  assign data_in = oe_n ? ~last : word;
  always @(posedge clk) begin
    if (data_oe)
      word <= data_out;
    if (!oe_n)
      last <= word;
  end
endmodule
`default_nettype wire

/* programmable_sync_memory_port_test.sv */
// Testbench for psmp_port: APB tasks, one memory word, two free clocks.
// Assumes psmp_cfg.svh and psmp_pkg are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "psmp_cfg.svh"
module programmable_sync_memory_port_test;
  import psmp_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e1 = 0, e2 = 0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd, mdi, mdo;
  logic pready, pslverr, err, oe_n, we_n, st_n, doe, narrow, wl_done;
  logic [3:0] ce_n, ce_seen;
  logic [19:0] maddr;
  int err_count = 0, checks_done = 0, rl_t, wl_t, ce_t, st_t;
  psmp_sec_t sec;
  wire sclk = sec.clk_sel ? e2 : e1;
  initial forever #4 pclk = ~pclk;
  // Odd offsets keep memory edges off pclk edges
  initial begin #1.3; forever #62.5 e1 = ~e1; end
  initial begin #2.1; forever #94.5 e2 = ~e2; end
  psmp_port #(.PORT_NARROW(1'b1)) i_psmp_port (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .ext_clock_out_one(e1),
    .ext_clock_out_two(e2), .space_chip_enable_n(ce_n), .addr_strobe_or_read_enable_n(st_n),
    .sync_output_enable_n(oe_n), .sync_write_enable_n(we_n), .mem_addr(maddr),
    .mem_data_out(mdo), .mem_data_oe(doe), .mem_data_in(mdi), .port_is_narrow(narrow));
  psmp_mem_model i_psmp_mem_model (.clk(sclk), .oe_n(oe_n), .data_oe(doe), .data_out(mdo),
    .data_in(mdi));
  ////////////////////////////////////////////////////////////////
  // Pin lengths in ticks of the selected clock
  always @(posedge sclk) begin
    rl_t += !oe_n;
    st_t += !st_n;
    wl_t += !doe && !wl_done;
    if (ce_n != 4'hF) begin
      ce_t++;
      ce_seen |= ~ce_n;
    end
  end
  always @(negedge we_n) wl_t = 0;
  always @(posedge doe) wl_done = 1;
  ////////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wait_idle;
    do apb(0, `PSMP_OFF_STATUS, 0); while (rd[0] !== 1'b0);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Whole run is some 5 us; a hang stops at the 200 us limit, far above that
  initial begin #200000; err_count++; conclude; end
  initial begin
    sec = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1;
    apb(0, `PSMP_OFF_SEC1, 0); chk(rd, 0, "sec1 reset");
    apb(1, `PSMP_OFF_SEC0, 32'hFFFFFFFF);
    apb(0, `PSMP_OFF_SEC0, 0); chk(rd, 32'h7F, "sec0 fields");
    apb(0, 12'h024, 0); chk({31'h0, err}, 1, "unmapped");
    chk({31'h0, narrow}, 1, "identity");
    for (int i = 0; i < 4; i++) begin
      sec = {i[0] ^ i[1], i[1], i[0], 2'(3 - i), 2'(i)};
      apb(1, 12'(4 * i), 32'(sec));
      apb(1, `PSMP_OFF_ADDR, 32'h100 + i);
      apb(1, `PSMP_OFF_WDATA, 32'hC0DE0000 + i);
      {wl_done, ce_seen, st_t} = 0;
      apb(1, `PSMP_OFF_CMD, 32'(2 * i));
      wait_idle;
      chk(wl_t, 3 - i, "write latency");
      chk({28'h0, ce_seen}, 32'(1 << i), "space");
      chk({12'h0, maddr}, 32'h100 + i, "address");
      chk(st_t, i[1] ? 0 : 1, "write strobe");
      {rl_t, ce_t, st_t} = 0;
      apb(1, `PSMP_OFF_CMD, 32'(2 * i + 1));
      apb(1, `PSMP_OFF_CMD, 32'(2 * i + 1)); chk({31'h0, err}, 1, "busy command");
      wait_idle; chk(rd, 32'h2, "error flag");
      apb(1, `PSMP_OFF_STATUS, 32'h2);
      apb(0, `PSMP_OFF_RDATA, 0); chk(rd, 32'hC0DE0000 + i, "read data");
      chk(rl_t, i + 1, "read latency");
      chk(ce_t, i[0] ? i + 1 : 1, "enable length");
      chk(st_t, i[1] ? i + 1 : 1, "strobe length");
    end
    apb(0, `PSMP_OFF_STATUS, 0); chk(rd, 0, "error cleared");
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    apb(0, `PSMP_OFF_SEC3, 0); chk(rd, 0, "sec3 after reset");
    apb(0, `PSMP_OFF_RDATA, 0); chk(rd, 0, "rdata after reset");
    conclude;
  end
endmodule
`default_nettype wire
